// *** verilog/swr_regbank.sv ***
`timescale 1ns/10ps
module swr_regbank #(
    parameter logic [7:0] VERSION_ID = 8'hA5  // arbitrary value
) (
    input  wire logic i_ref_clk,
    input  wire logic i_rstn,
    input  wire logic i_ce,
    input  wire logic i_scl,
    input  wire logic i_sda,
    output logic      o_sda_out,
    output logic      o_sda_oe,
    input  wire logic i_evt_recovered,
    input  wire logic i_evt_overcurrent,
    input  wire logic i_evt_overvoltage,
    input  wire logic i_evt_long_release,
    input  wire logic i_evt_long_press,
    input  wire logic i_evt_key_press,
    input  wire logic i_evt_stuck_key,
    input  wire logic i_evt_stuck_recovered,
    input  wire logic i_evt_adc_change,
    input  wire logic i_id_detect_done,
    output logic      o_switch_follow_detect,
    output logic      o_auto_config,
    output logic      o_manual_select,
    output logic      o_host_interrupt_n
);
    import swr_pkg::*;

    logic [1:0] pin_raw;
    logic [1:0] pin_filt;
    logic       scl_f;
    logic       sda_f;
    logic       scl_d;
    logic       sda_d;
    logic       scl_rise;
    logic       scl_fall;
    logic       bus_start;
    logic       bus_stop;
    swr_state_t state;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic [7:0] tx;
    logic [7:0] ptr;
    logic       rw;
    logic       receiving;
    logic       byte_done;
    logic       wr_en;
    logic       load;
    logic [7:0] rd_byte;
    logic [7:0] ctl;
    logic [7:0] mask1;
    logic [7:0] mask2;
    logic [7:0] flag1;
    logic [7:0] flag2;
    logic [7:0] set1;
    logic [7:0] set2;
    logic [7:0] clr1;
    logic [7:0] clr2;
    logic       adc_evt;

    assign pin_raw = {i_sda, i_scl};
    assign scl_f   = pin_filt[0];
    assign sda_f   = pin_filt[1];

    // two-stage sync, then a value must hold FILT_CYC samples to pass
    for (genvar g = 0; g < 2; g++)
    begin : gen_pin
        logic       sync_a;
        logic       sync_b;
        logic       filt;
        logic [1:0] cnt;
        always_ff @(posedge i_ref_clk)
        begin
            if (!i_rstn)
            begin
                sync_a <= 1'b1;
                sync_b <= 1'b1;
                filt   <= 1'b1;
                cnt    <= 2'h0;
            end
            else if (i_ce)
            begin
                sync_a <= pin_raw[g];
                sync_b <= sync_a;
                if (sync_b == filt)
                    cnt <= 2'h0;
                else if (cnt == FILT_LAST)
                begin
                    filt <= sync_b;
                    cnt  <= 2'h0;
                end
                else
                    cnt <= cnt + 2'h1;
            end
        end
        assign pin_filt[g] = filt;
    end

    // previous filtered levels for edge and start/stop detection
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rstn)
        begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end
        else if (i_ce)
        begin
            scl_d <= scl_f;
            sda_d <= sda_f;
        end
    end

    assign scl_rise  = scl_f & ~scl_d;
    assign scl_fall  = ~scl_f & scl_d;
    assign bus_start = scl_f & scl_d & sda_d & ~sda_f;
    assign bus_stop  = scl_f & scl_d & ~sda_d & sda_f;
    assign receiving = (state == ST_ADDR) || (state == ST_PTR)
                    || (state == ST_WR);
    assign byte_done = receiving && scl_fall && (bitcnt == BITS_PER_BYTE);
    assign wr_en     = i_ce && !bus_start && !bus_stop
                    && (state == ST_WR) && byte_done;
    assign load      = i_ce && !bus_start && !bus_stop && scl_fall
                    && (((state == ST_ACK_ADDR) && rw)
                    || (state == ST_ACK_RD));

    // byte-level sequencing; a start restarts from any state
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rstn)
            state <= ST_IDLE;
        else if (i_ce)
        begin
            if (bus_start)
                state <= ST_ADDR;
            else if (bus_stop)
                state <= ST_IDLE;
            else
                unique case (state)
                    ST_IDLE: ;
                    ST_ADDR:
                        if (byte_done)
                            state <= (shreg[7:1] == DEV_ADDR)
                                   ? ST_ACK_ADDR : ST_IDLE;
                    ST_ACK_ADDR:
                        if (scl_fall)
                            state <= rw ? ST_RD : ST_PTR;
                    ST_PTR:
                        if (byte_done)
                            state <= ST_ACK_PTR;
                    ST_ACK_PTR, ST_ACK_WR:
                        if (scl_fall)
                            state <= ST_WR;
                    ST_WR:
                        if (byte_done)
                            state <= ST_ACK_WR;
                    ST_RD:
                        if (scl_fall && bitcnt == LAST_BIT)
                            state <= ST_ACK_RD;
                    ST_ACK_RD:
                        if (scl_rise && sda_f)        // controller NACK
                            state <= ST_IDLE;
                        else if (scl_fall)
                            state <= ST_RD;
                endcase
        end
    end

    // bit counter, shift register, direction bit
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rstn)
        begin
            bitcnt <= 4'h0;
            shreg  <= 8'h00;
            rw     <= 1'b0;
        end
        else if (i_ce)
        begin
            if (bus_start || byte_done || load)
                bitcnt <= 4'h0;
            else if (receiving && scl_rise)
            begin
                bitcnt <= bitcnt + 4'h1;
                shreg  <= {shreg[6:0], sda_f};
            end
            else if (state == ST_RD && scl_fall)
                bitcnt <= (bitcnt == LAST_BIT) ? 4'h0 : bitcnt + 4'h1;
            if (state == ST_ADDR && byte_done)
                rw <= shreg[0];
        end
    end

    // pointer auto-increments after every data byte in either direction
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rstn)
            ptr <= 8'h00;
        else if (i_ce && !bus_start && !bus_stop)
        begin
            if (state == ST_PTR && byte_done)
                ptr <= shreg;
            else if (load || (state == ST_ACK_WR && scl_fall))
                ptr <= ptr + 8'h01;
        end
    end

    // read mux; unmapped offsets read as zero
    always_comb
    begin
        unique case (ptr)
            REG_VERSION: rd_byte = VERSION_ID;
            REG_CTL:     rd_byte = ctl & CTL_BITS;
            REG_FLAG1:   rd_byte = flag1;
            REG_FLAG2:   rd_byte = flag2;
            REG_MASK1:   rd_byte = mask1;
            REG_MASK2:   rd_byte = mask2;
            default:     rd_byte = 8'h00;
        endcase
    end

    // transmit shifter; msb goes out first
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rstn)
            tx <= 8'hFF;
        else if (i_ce)
        begin
            if (load)
                tx <= rd_byte;
            else if (state == ST_RD && scl_fall && bitcnt != LAST_BIT)
                tx <= {tx[6:0], 1'b1};
        end
    end

    // open-drain data: only ever pull low, for ack or a zero data bit
    assign o_sda_out = 1'b0;
    assign o_sda_oe  = (state == ST_ACK_ADDR) || (state == ST_ACK_PTR)
                    || (state == ST_ACK_WR)
                    || ((state == ST_RD) && !tx[7]);

    // writable registers; reserved bits are dropped on write
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rstn)
        begin
            ctl   <= CTL_RST;
            mask1 <= MASK_RST;
            mask2 <= MASK_RST;
        end
        else if (wr_en)
        begin
            unique case (ptr)
                REG_CTL:   ctl   <= shreg & CTL_BITS;
                REG_MASK1: mask1 <= shreg & FLAG1_BITS;
                REG_MASK2: mask2 <= shreg & FLAG2_BITS;
                default: ;
            endcase
        end
    end

    assign o_switch_follow_detect = ctl[CTL_SW_OPEN];
    assign o_auto_config          = ctl[CTL_AUTO];
    assign o_manual_select        = ~ctl[CTL_AUTO];

    // detection done and ADC change share one flag, both gated by bit 3
    assign adc_evt = (i_evt_adc_change | i_id_detect_done)
                   & ~ctl[CTL_ADC_INT_DIS];
    assign set1 = {i_evt_recovered, i_evt_overcurrent, i_evt_overvoltage,
                   i_evt_long_release, i_evt_long_press, i_evt_key_press,
                   2'b00};
    assign set2 = {3'b000, i_evt_stuck_recovered, i_evt_stuck_key,
                   adc_evt, 2'b00};
    // clear only what was loaded for sending, so a new event is kept
    assign clr1 = (load && ptr == REG_FLAG1) ? flag1 : 8'h00;
    assign clr2 = (load && ptr == REG_FLAG2) ? flag2 : 8'h00;

    // sticky flags; a set in the clearing cycle wins
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rstn)
        begin
            flag1 <= FLAG_RST;
            flag2 <= FLAG_RST;
        end
        else if (i_ce)
        begin
            flag1 <= (flag1 & ~clr1) | set1;
            flag2 <= (flag2 & ~clr2) | set2;
        end
    end

    // interrupt follows flags one cycle later
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rstn)
            o_host_interrupt_n <= 1'b1;
        else if (i_ce)
            o_host_interrupt_n <= ~|((flag1 & ~mask1)
                                  | (flag2 & ~mask2));
    end

    a_addr_match:
    assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        state == ST_ACK_ADDR |-> shreg[7:1] == DEV_ADDR && o_sda_oe)
        else $error("ack given to a foreign address");

    a_spike_reject:
    assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        $changed(scl_f) |-> $past(gen_pin[0].sync_b, 1) == scl_f
            && $past(gen_pin[0].sync_b, 2) == scl_f
            && $past(gen_pin[0].sync_b, 3) == scl_f)
        else $error("clock filter passed a short pulse");

    a_ctl_reset:
    assert property (@(posedge i_ref_clk)
        !i_rstn |=> ctl == CTL_RST && flag1 == FLAG_RST)
        else $error("control or flags wrong after reset");

    a_ctl_resv:
    assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        load && ptr == REG_CTL |=> tx[7:5] == 3'b000)
        else $error("reserved control bits read nonzero");

    a_sw_follow:
    assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        wr_en && ptr == REG_CTL
        |=> o_switch_follow_detect == $past(shreg[CTL_SW_OPEN]))
        else $error("switch-open bit not taken from write");

    a_adc_hide:
    assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        ctl[CTL_ADC_INT_DIS] && !flag2[F2_ADC_CHANGE]
        |=> !flag2[F2_ADC_CHANGE])
        else $error("ADC change flagged while disabled");

    a_auto_sel:
    assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        wr_en && ptr == REG_CTL
        |=> o_auto_config == $past(shreg[CTL_AUTO])
            && o_manual_select != o_auto_config)
        else $error("automatic select not taken from write");

    a_flag1_clear:
    assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        load && ptr == REG_FLAG1 && set1 == 8'h00 |=> flag1 == 8'h00)
        else $error("first flags not cleared by read");

    a_fault_set:
    assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        i_ce && i_evt_overcurrent |=> flag1[F1_OVERCURRENT])
        else $error("overcurrent event lost");

    a_key_set:
    assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        i_ce && i_evt_long_press |=> flag1[F1_LONG_PRESS])
        else $error("long key press lost");

    a_flag2_clear:
    assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        load && ptr == REG_FLAG2 && set2 == 8'h00 |=> flag2 == 8'h00)
        else $error("second flags not cleared by read");

    a_stuck_set:
    assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        i_ce && i_evt_stuck_key |=> flag2[F2_STUCK_KEY])
        else $error("stuck key event lost");

    a_stuck_recov:
    assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        i_ce && i_evt_stuck_recovered |=> flag2[F2_STUCK_RECOVERED])
        else $error("stuck key recovery lost");

    a_adc_set:
    assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        i_ce && i_evt_adc_change && !ctl[CTL_ADC_INT_DIS]
        |=> flag2[F2_ADC_CHANGE])
        else $error("ADC change lost");

    a_mask_quiet:
    assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        i_ce && (flag1 & ~mask1) == 8'h00 && (flag2 & ~mask2) == 8'h00
        |=> o_host_interrupt_n)
        else $error("masked flag reached the host");

    a_irq_assert:
    assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        i_ce && |(flag1 & ~mask1) |=> !o_host_interrupt_n)
        else $error("unmasked flag without interrupt");

endmodule

// *** verilog/swr_pkg.sv ***
package swr_pkg;

    // target address, upper seven bits of the address byte
    localparam logic [6:0] DEV_ADDR      = 7'h25;

    // register offsets
    localparam logic [7:0] REG_VERSION   = 8'h01;
    localparam logic [7:0] REG_CTL       = 8'h02;
    localparam logic [7:0] REG_FLAG1     = 8'h03;
    localparam logic [7:0] REG_FLAG2     = 8'h04;
    localparam logic [7:0] REG_MASK1     = 8'h05;
    localparam logic [7:0] REG_MASK2     = 8'h06;

    // reset values and writable / implemented bits
    localparam logic [7:0] CTL_RST       = 8'h1F;
    localparam logic [7:0] FLAG_RST      = 8'h00;
    localparam logic [7:0] MASK_RST      = 8'h00;
    localparam logic [7:0] CTL_BITS      = 8'h1F;
    localparam logic [7:0] FLAG1_BITS    = 8'hFC;
    localparam logic [7:0] FLAG2_BITS    = 8'h1C;

    // control fields
    localparam int CTL_SW_OPEN           = 4;
    localparam int CTL_ADC_INT_DIS       = 3;
    localparam int CTL_AUTO              = 2;

    // first flag register fields
    localparam int F1_RECOVERED          = 7;
    localparam int F1_OVERCURRENT        = 6;
    localparam int F1_OVERVOLTAGE        = 5;
    localparam int F1_LONG_RELEASE       = 4;
    localparam int F1_LONG_PRESS         = 3;
    localparam int F1_KEY_PRESS          = 2;

    // second flag register fields
    localparam int F2_STUCK_RECOVERED    = 4;
    localparam int F2_STUCK_KEY          = 3;
    localparam int F2_ADC_CHANGE         = 2;

    // spike filter: a pulse of SPIKE_NS fits in FILT_CYC - 1 samples
    localparam int SPIKE_NS              = 50;
    localparam int CLK_PERIOD_NS         = 40;
    localparam int FILT_CYC              =
        (SPIKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
    localparam logic [1:0] FILT_LAST     = 2'(FILT_CYC - 1);

    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] LAST_BIT      = 4'h7;

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ACK_ADDR,
        ST_PTR,
        ST_ACK_PTR,
        ST_WR,
        ST_ACK_WR,
        ST_RD,
        ST_ACK_RD
    } swr_state_t;

endpackage

// *** tb/swr_host_model.sv ***
`timescale 1ns/10ps
module swr_host_model
    import swr_pkg::*;
#(
    parameter int LOW_CYC  = 33,
    parameter int HIGH_CYC = 16
) (
    input  wire logic i_ref_clk,
    input  wire logic i_sda_line,
    output logic      o_scl,
    output logic      o_sda_low
);
    // bench-controlled knobs; initialised here so only the bench writes them
    logic       glitch = 1'b0;
    int         slow   = 0;
    logic [7:0] rd_buf [8];

    // bus idle: clock high, data released to its pull-up
    initial
    begin
        o_scl     = 1'b1;
        o_sda_low = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge i_ref_clk);
    endtask

    // one bit: data moves mid-low, sampled mid-high on a settled line;
    // glitch adds one-cycle spikes that the target must not see
    task automatic bit_slot(input logic drive_low, output logic seen);
        tick(LOW_CYC / 2 + slow);
        o_sda_low <= drive_low;
        if (glitch)
        begin
            tick(3);
            o_scl <= 1'b1;
            tick(1);
            o_scl <= 1'b0;
        end
        tick(LOW_CYC - LOW_CYC / 2);
        o_scl <= 1'b1;
        tick(HIGH_CYC / 2);
        @(negedge i_ref_clk);
        seen = i_sda_line;
        if (glitch)
        begin
            @(posedge i_ref_clk);
            o_sda_low <= ~drive_low;
            @(posedge i_ref_clk);
            o_sda_low <= drive_low;
        end
        tick(HIGH_CYC - HIGH_CYC / 2);
        o_scl <= 1'b0;
    endtask

    // works from idle and, as a repeated start, from clock low
    task automatic start_cond();
        tick(LOW_CYC / 2);
        o_sda_low <= 1'b0;
        tick(LOW_CYC / 2);
        o_scl <= 1'b1;
        tick(HIGH_CYC);
        o_sda_low <= 1'b1;
        tick(HIGH_CYC);
        o_scl <= 1'b0;
    endtask

    // trailing low time keeps the bus-free gap before the next start
    task automatic stop_cond();
        tick(LOW_CYC / 2);
        o_sda_low <= 1'b1;
        tick(LOW_CYC / 2);
        o_scl <= 1'b1;
        tick(HIGH_CYC);
        o_sda_low <= 1'b0;
        tick(LOW_CYC);
    endtask

    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_slot(~b[i], s);
        bit_slot(1'b0, s);
        ack = ~s;
    endtask

    task automatic recv_byte(input logic last, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--)
        begin
            bit_slot(1'b0, s);
            b[i] = s;
        end
        bit_slot(~last, s);
    endtask

    // address byte alone, to see whether the target claims it
    task automatic probe(input logic [7:0] addr, output logic ack);
        start_cond();
        send_byte(addr, ack);
        stop_cond();
    endtask

    task automatic write_reg(input logic [7:0] ptr, input logic [7:0] data,
                             output logic [2:0] acks);
        start_cond();
        send_byte({DEV_ADDR, 1'b0}, acks[2]);
        send_byte(ptr, acks[1]);
        send_byte(data, acks[0]);
        stop_cond();
    endtask

    // pointer write, repeated start, n bytes with the last one refused
    task automatic read_regs(input logic [7:0] ptr, input int n);
        logic a;
        start_cond();
        send_byte({DEV_ADDR, 1'b0}, a);
        send_byte(ptr, a);
        start_cond();
        send_byte({DEV_ADDR, 1'b1}, a);
        for (int i = 0; i < n; i++)
            recv_byte(i == n - 1, rd_buf[i]);
        stop_cond();
    endtask
endmodule

// *** tb/testbench.sv ***
`timescale 1ns/10ps
module testbench;
    import swr_pkg::*;

    localparam logic [7:0] VER = 8'h3C;  // arbitrary value
    // flag bit expected from each event input, first register first
    localparam logic [7:0] EVT_MASK [10] = '{8'h80, 8'h40, 8'h20, 8'h10,
        8'h08, 8'h04, 8'h08, 8'h10, 8'h04, 8'h04};
    // control values, reserved bits always written as zero
    localparam logic [7:0] CTL_VAL [4] = '{8'h00, 8'h13, 8'h04, 8'h1F};

    logic       i_ref_clk = 1'b0;
    logic       i_rstn    = 1'b0;
    logic       i_ce      = 1'b1;
    logic [9:0] evt       = '0;
    logic       host_scl;
    logic       host_sda_low;
    logic       sda_line;
    logic       o_sda_out;
    logic       o_sda_oe;
    logic       o_switch_follow_detect;
    logic       o_auto_config;
    logic       o_manual_select;
    logic       o_host_interrupt_n;
    logic [2:0] acks;
    logic       ack;
    int         mismatches = 0;
    int         samples_checked = 0;

    always #20 i_ref_clk = ~i_ref_clk;

    // open-drain data line with pull-up: low if either party pulls
    assign sda_line = ~(host_sda_low | (o_sda_oe & ~o_sda_out));

    swr_host_model u_swr_host_model (
        .i_ref_clk  (i_ref_clk),
        .i_sda_line (sda_line),
        .o_scl      (host_scl),
        .o_sda_low  (host_sda_low)
    );

    swr_regbank #(.VERSION_ID(VER)) u_swr_regbank (
        .i_ref_clk              (i_ref_clk),
        .i_rstn                 (i_rstn),
        .i_ce                   (i_ce),
        .i_scl                  (host_scl),
        .i_sda                  (sda_line),
        .o_sda_out              (o_sda_out),
        .o_sda_oe               (o_sda_oe),
        .i_evt_recovered        (evt[0]),
        .i_evt_overcurrent      (evt[1]),
        .i_evt_overvoltage      (evt[2]),
        .i_evt_long_release     (evt[3]),
        .i_evt_long_press       (evt[4]),
        .i_evt_key_press        (evt[5]),
        .i_evt_stuck_key        (evt[6]),
        .i_evt_stuck_recovered  (evt[7]),
        .i_evt_adc_change       (evt[8]),
        .i_id_detect_done       (evt[9]),
        .o_switch_follow_detect (o_switch_follow_detect),
        .o_auto_config          (o_auto_config),
        .o_manual_select        (o_manual_select),
        .o_host_interrupt_n     (o_host_interrupt_n)
    );

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic wr(input logic [7:0] ptr, input logic [7:0] data);
        u_swr_host_model.write_reg(ptr, data, acks);
        check({5'h0, acks}, 8'h07);
    endtask

    task automatic rd_chk(input logic [7:0] ptr, input logic [7:0] exp);
        u_swr_host_model.read_regs(ptr, 1);
        check(u_swr_host_model.rd_buf[0], exp);
    endtask

    // one-cycle event pulse, then time for flag and interrupt to land
    task automatic fire(input int k);
        @(posedge i_ref_clk);
        evt <= 10'h001 << k;
        @(posedge i_ref_clk);
        evt <= '0;
        repeat (3) @(posedge i_ref_clk);
    endtask

    function automatic logic [7:0] ctl_pins();
        return {5'h0, o_switch_follow_detect, o_auto_config,
                o_manual_select};
    endfunction

    // a hang never reaches the verdict by itself; the bus walk needs ~69k
    initial
    begin
        repeat (95000) @(posedge i_ref_clk);
        mismatches++;
        close_out();
    end

    // main sequence
    initial
    begin
        repeat (12) @(posedge i_ref_clk);
        i_rstn <= 1'b1;
        repeat (10) @(posedge i_ref_clk);
        check(ctl_pins(), 8'h06);
        check({7'h0, o_host_interrupt_n}, 8'h01);
        u_swr_host_model.read_regs(REG_VERSION, 6);
        check(u_swr_host_model.rd_buf[0], VER);
        check(u_swr_host_model.rd_buf[1], 8'h1F);
        check(u_swr_host_model.rd_buf[2], 8'h00);
        check(u_swr_host_model.rd_buf[3], 8'h00);
        check(u_swr_host_model.rd_buf[4], 8'h00);
        check(u_swr_host_model.rd_buf[5], 8'h00);
        wr(REG_VERSION, 8'h00);
        rd_chk(REG_VERSION, VER);
        $display("test reset_values done");

        u_swr_host_model.probe(8'h4C, ack);
        check({7'h0, ack}, 8'h00);
        u_swr_host_model.probe(8'h4A, ack);
        check({7'h0, ack}, 8'h01);
        $display("test address done");

        for (int i = 0; i < 4; i++)
        begin
            wr(REG_CTL, CTL_VAL[i]);
            check(ctl_pins(), {5'h0, CTL_VAL[i][4], CTL_VAL[i][2],
                               ~CTL_VAL[i][2]});
            rd_chk(REG_CTL, CTL_VAL[i]);
        end
        $display("test control done");

        // spikes on both lines and a sluggish clock must change nothing
        u_swr_host_model.glitch = 1'b1;
        u_swr_host_model.slow = 20;
        wr(REG_CTL, 8'h0B);
        rd_chk(REG_CTL, 8'h0B);
        u_swr_host_model.glitch = 1'b0;
        u_swr_host_model.slow = 0;
        $display("test spike_filter done");

        wr(REG_CTL, 8'h14);
        for (int k = 0; k < 10; k++)
        begin
            fire(k);
            check({7'h0, o_host_interrupt_n}, 8'h00);
            rd_chk(k < 6 ? REG_FLAG1 : REG_FLAG2, EVT_MASK[k]);
            if (k == 5 || k == 9)
                rd_chk(k < 6 ? REG_FLAG1 : REG_FLAG2, 8'h00);
            check({7'h0, o_host_interrupt_n}, 8'h01);
        end
        $display("test event_flags done");

        wr(REG_CTL, 8'h1C);
        fire(8);
        fire(9);
        check({7'h0, o_host_interrupt_n}, 8'h01);
        rd_chk(REG_FLAG2, 8'h00);
        $display("test adc_disable done");

        // masked flags still latch but keep the interrupt quiet
        wr(REG_MASK1, 8'h04);
        wr(REG_MASK2, 8'h08);
        fire(5);
        fire(6);
        check({7'h0, o_host_interrupt_n}, 8'h01);
        rd_chk(REG_FLAG1, 8'h04);
        rd_chk(REG_FLAG2, 8'h08);
        wr(REG_MASK1, 8'h00);
        fire(5);
        check({7'h0, o_host_interrupt_n}, 8'h00);
        rd_chk(REG_FLAG1, 8'h04);
        check({7'h0, o_host_interrupt_n}, 8'h01);
        $display("test masks done");

        // with the enable low an event pulse must leave no trace at all
        @(posedge i_ref_clk);
        i_ce <= 1'b0;
        fire(0);
        @(posedge i_ref_clk);
        i_ce <= 1'b1;
        check({7'h0, o_host_interrupt_n}, 8'h01);
        rd_chk(REG_FLAG1, 8'h00);
        $display("test clock_enable done");
        close_out();
    end
endmodule
